// >>> crt_monitor_model.sv
// sync monitor model: counts line syncs seen in each frame
`timescale 1ns/100ps
module crt_monitor_model (
    input  wire logic        sys_clk,    // system clock
    input  wire logic        hretrace,   // line sync from the block
    input  wire logic        frame_sync, // frame marker, restarts the count
    output logic      [15:0] sync_count  // syncs seen since the last frame
);
    logic last_sync; // previous sync level, for edge detection
    // a sync is counted once, on its rising edge; a stuck level adds nothing
    always_ff @(posedge sys_clk) begin
        last_sync  <= hretrace;
        sync_count <= frame_sync ? 16'h0000 : sync_count + 16'(hretrace & ~last_sync);
    end
endmodule

// >>> crt_raster_timing_checker.sv
// port checker for the raster timing block
`timescale 1ns/100ps
module crt_raster_timing_checker
    import crt_timing_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        char_tick,
    input wire logic        colour_select,
    input wire logic [15:0] io_addr,
    input wire logic        io_read,
    input wire logic        io_hit,
    input wire logic [7:0]  char_count,
    input wire logic [9:0]  line_count,
    input wire logic        frame_start,
    input wire logic [4:0]  row_scan
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // the data port answers only at the base that emulation selects
    property p_hit_own; io_read && io_addr == (colour_select ? COLOUR_DATA_PORT : MONO_DATA_PORT) |=> io_hit; endproperty
    a_hit_own: assert property (p_hit_own) else $error("own port missed");
    property p_hit_other; io_read && io_addr == (colour_select ? MONO_DATA_PORT : COLOUR_DATA_PORT) |=> !io_hit; endproperty
    a_hit_other: assert property (p_hit_other) else $error("foreign port claimed");
    property p_hit_idle; !io_read |=> !io_hit; endproperty
    a_hit_idle: assert property (p_hit_idle) else $error("claim without read");
    // counters move only on character ticks, so idle cycles hold them
    property p_char_step; char_tick |=> char_count == $past(char_count) + 8'h01 || char_count == 8'h00; endproperty
    a_char_step: assert property (p_char_step) else $error("char counter step");
    property p_char_hold; !char_tick |=> $stable(char_count); endproperty
    a_char_hold: assert property (p_char_hold) else $error("char counter moved");
    property p_line_hold; !char_tick |=> $stable(line_count); endproperty
    a_line_hold: assert property (p_line_hold) else $error("line counter moved");
    property p_row_hold; !char_tick |=> $stable(row_scan); endproperty
    a_row_hold: assert property (p_row_hold) else $error("row scan moved");
    property p_frame_zero; frame_start |-> line_count == 10'h000; endproperty
    a_frame_zero: assert property (p_frame_zero) else $error("frame start off line zero");
    cover property (frame_start);
    cover property (io_read && !colour_select ##1 io_hit);
    cover property (char_tick && char_count == 8'h00);
endmodule
bind crt_raster_timing_regs crt_raster_timing_checker checker_inst (.sys_clk, .resetn, .char_tick, .colour_select,
    .io_addr, .io_read, .io_hit, .char_count, .line_count, .frame_start, .row_scan);

// >>> crt_raster_timing_regs.sv
// raster timing counters and indexed timing register bank
`timescale 1ns/100ps
module crt_raster_timing_regs
    import crt_timing_pkg::*;
(
    input  wire logic        sys_clk,            // 250 mhz system clock
    input  wire logic        resetn,             // asynchronous reset, low active
    input  wire logic        char_tick,          // one character clock, same domain pulse
    input  wire logic        colour_select,      // emulation select from misc output
    input  wire logic        write_protect,      // protect bit of vertical retrace end
    input  wire logic [4:0]  cursor_end_row,     // cursor end field, external register
    input  wire logic [15:0] io_addr,            // host i/o address
    input  wire logic        io_write,           // host write strobe, one cycle
    input  wire logic        io_read,            // host read strobe, one cycle
    input  wire logic [7:0]  io_wdata,           // host write data
    output logic      [7:0]  io_rdata,           // registered read data
    output logic             io_hit,             // registered: last read claimed
    output logic             display_enable,     // skewed horizontal display enable
    output logic             hblank,             // internal horizontal blanking
    output logic             hretrace,           // skewed horizontal retrace
    output logic      [7:0]  char_count,         // horizontal character counter
    output logic      [9:0]  line_count,         // vertical line counter
    output logic             frame_start,        // pulse at vertical wrap
    output logic      [4:0]  row_scan,           // row scan counter
    output logic             cursor_row,         // cursor active on this row
    output logic      [1:0]  byte_pan,           // byte panning extension
    output logic      [9:0]  vblank_start_high,  // bits 9,8 of vertical blank start
    output logic      [9:0]  line_compare_high,  // bits 9,8 of line compare
    output logic      [9:0]  vdisplay_end_high,  // bits 9,8 of vertical display end
    output logic      [9:0]  vretrace_start_high // bits 9,8 of vertical retrace start
);
    import crt_timing_pkg::*;

    // skew select: pick undelayed or one of three delayed copies
    function automatic logic skew_pick(input logic now, input logic [2:0] dly, input logic [1:0] code);
        logic r;
        r = now;
        unique case (code)
            2'b00: r = now;
            2'b01: r = dly[0];
            2'b10: r = dly[1];
            2'b11: r = dly[2];
        endcase
        return r;
    endfunction

    logic [1:0] rst_sync;                // reset release synchroniser
    logic       rst_n;                   // design reset, released synchronously
    logic [5:0] timing_index;            // index register, bits 7,6 read zero
    logic [7:0] horizontal_total;        // line length minus five
    logic [7:0] horizontal_display_end;  // displayed characters minus one
    logic [7:0] horizontal_blank_start;  // blanking start character
    logic [7:0] horizontal_blank_end;    // blank end low bits and skew
    logic [7:0] horizontal_retrace_start;// retrace start character
    logic [7:0] horizontal_retrace_end;  // retrace end, delay, blank end bit 5
    logic [7:0] vertical_total;          // vertical total low bits
    logic [7:0] vertical_overflow_bits;  // vertical extension bits
    logic [7:0] preset_row_scan;         // preset row and byte pan
    logic [7:0] max_scan_line;           // rows per character, doubling
    logic [7:0] cursor_start_row;        // cursor start row
    logic       index_port;              // address hits index port
    logic       data_port;               // address hits data port
    logic       data_write;              // write to data port
    logic       protected_index;         // chosen register is write protected
    logic [7:0] next_rdata;              // read mux result
    logic       line_end;                // last character of the line
    logic [9:0] vtotal_full;             // ten-bit vertical total
    logic       de_raw;                  // display enable before skew
    logic [2:0] de_dly;                  // display enable delay line
    logic       retrace_raw;             // retrace before skew
    logic [2:0] retrace_dly;             // retrace delay line
    logic [5:0] blank_end_full;          // six-bit blank end value
    row_phase_type row_phase;            // line doubling divider
    logic       retrace_start_hit;       // counter at retrace start
    logic [5:0] cursor_first;            // first cursor row, one past start
    logic       frame_end;               // last line of the frame

    // reset is asserted at once and released after two clock edges
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // port decode follows the emulation select
    always_comb begin
        if (colour_select) begin
            index_port = (io_addr == COLOUR_INDEX_PORT);
            data_port  = (io_addr == COLOUR_DATA_PORT);
        end else begin
            index_port = (io_addr == MONO_INDEX_PORT);
            data_port  = (io_addr == MONO_DATA_PORT);
        end
    end

    assign data_write      = io_write && data_port;
    // indexes 0 to 7 share the protect bit
    assign protected_index = write_protect && (timing_index[4:0] <= IDX_LAST_PROTECTED);

    // index register holds until rewritten; test bit stored as written
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timing_index <= REG_RESET_VALUE[5:0];
        end else if (io_write && index_port) begin
            timing_index <= io_wdata[5:0] & INDEX_WRITE_MASK;
        end
    end

    // horizontal registers, protected as a group
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            horizontal_total         <= REG_RESET_VALUE;
            horizontal_display_end   <= REG_RESET_VALUE;
            horizontal_blank_start   <= REG_RESET_VALUE;
            horizontal_blank_end     <= REG_RESET_VALUE;
            horizontal_retrace_start <= REG_RESET_VALUE;
            horizontal_retrace_end   <= REG_RESET_VALUE;
        end else if (data_write && !protected_index) begin
            // the decode uses the low five index bits only
            unique case (timing_index[4:0])
                IDX_HORIZONTAL_TOTAL:   horizontal_total         <= io_wdata;
                IDX_HORIZONTAL_DISPLAY: horizontal_display_end   <= io_wdata;
                IDX_HBLANK_START:       horizontal_blank_start   <= io_wdata;
                IDX_HBLANK_END:         horizontal_blank_end     <= io_wdata;
                IDX_HRETRACE_START:     horizontal_retrace_start <= io_wdata;
                IDX_HRETRACE_END:       horizontal_retrace_end   <= io_wdata;
                default: ;
            endcase
        end
    end

    // vertical total and overflow; line compare bit escapes protection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vertical_total         <= REG_RESET_VALUE;
            vertical_overflow_bits <= REG_RESET_VALUE;
        end else if (data_write) begin
            if (timing_index[4:0] == IDX_VERTICAL_TOTAL && !protected_index) begin
                vertical_total <= io_wdata;
            end else if (timing_index[4:0] == IDX_OVERFLOW) begin
                if (protected_index) begin
                    vertical_overflow_bits[OVF_LC_BIT8] <= io_wdata[OVF_LC_BIT8];
                end else begin
                    vertical_overflow_bits <= io_wdata;
                end
            end
        end
    end

    // unprotected registers at 8 to A
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            preset_row_scan  <= REG_RESET_VALUE;
            max_scan_line    <= REG_RESET_VALUE;
            cursor_start_row <= REG_RESET_VALUE;
        end else if (data_write) begin
            // indexes past A belong to other blocks and are ignored here
            unique case (timing_index[4:0])
                IDX_PRESET_ROW_SCAN: preset_row_scan  <= io_wdata;
                IDX_MAX_SCAN_LINE:   max_scan_line    <= io_wdata;
                IDX_CURSOR_START:    cursor_start_row <= io_wdata;
                default: ;
            endcase
        end
    end

    // read mux; indexes outside this part read zero
    always_comb begin
        next_rdata = REG_RESET_VALUE;
        if (index_port) begin
            next_rdata = {2'b00, timing_index};
        end else begin
            unique case (timing_index[4:0])
                IDX_HORIZONTAL_TOTAL:   next_rdata = horizontal_total;
                IDX_HORIZONTAL_DISPLAY: next_rdata = horizontal_display_end;
                IDX_HBLANK_START:       next_rdata = horizontal_blank_start;
                IDX_HBLANK_END:         next_rdata = horizontal_blank_end;
                IDX_HRETRACE_START:     next_rdata = horizontal_retrace_start;
                IDX_HRETRACE_END:       next_rdata = horizontal_retrace_end;
                IDX_VERTICAL_TOTAL:     next_rdata = vertical_total;
                IDX_OVERFLOW:           next_rdata = vertical_overflow_bits;
                IDX_PRESET_ROW_SCAN:    next_rdata = preset_row_scan;
                IDX_MAX_SCAN_LINE:      next_rdata = max_scan_line;
                IDX_CURSOR_START:       next_rdata = cursor_start_row;
                default:                next_rdata = REG_RESET_VALUE;
            endcase
        end
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata <= REG_RESET_VALUE;
            io_hit   <= 1'b0;
        end else if (io_read) begin
            io_rdata <= next_rdata;
            io_hit   <= index_port || data_port;
        end else begin
            io_hit   <= 1'b0;
        end
    end

    // a line is horizontal total plus five characters, count 0..total+4
    assign line_end = ({1'b0, char_count} == ({1'b0, horizontal_total} + HTOTAL_EXTRA));

    // horizontal character counter
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            char_count <= REG_RESET_VALUE;
        end else if (char_tick) begin
            if (line_end) begin
                char_count <= REG_RESET_VALUE;
            end else begin
                char_count <= char_count + 8'h01;
            end
        end
    end

    // display enable covers characters 0 through display end
    assign de_raw = (char_count <= horizontal_display_end);

    assign blank_end_full = {horizontal_retrace_end[BLANK_END_BIT5], horizontal_blank_end[4:0]};

    // blanking: set on start compare, cleared on six-bit end compare
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hblank <= 1'b0;
        end else if (char_tick) begin
            if (char_count == horizontal_blank_start) begin
                hblank <= 1'b1;
            end else if (char_count[5:0] == blank_end_full) begin
                hblank <= 1'b0;
            end
        end
    end

    assign retrace_start_hit = (char_count == horizontal_retrace_start);

    // retrace before skew; start wins if both compares meet
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            retrace_raw <= 1'b0;
        end else if (char_tick) begin
            if (retrace_start_hit) begin
                retrace_raw <= 1'b1;
            end else if (char_count[4:0] == horizontal_retrace_end[4:0]) begin
                retrace_raw <= 1'b0;
            end
        end
    end

    // delay lines step on the character clock so skew is in characters
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            de_dly      <= 3'h0;
            retrace_dly <= 3'h0;
        end else if (char_tick) begin
            de_dly      <= {de_dly[1:0], de_raw};
            retrace_dly <= {retrace_dly[1:0], retrace_raw};
        end
    end

    // skewed outputs registered to keep data outputs glitch free
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            display_enable <= 1'b0;
            hretrace       <= 1'b0;
        end else begin
            display_enable <= skew_pick(de_raw, de_dly, horizontal_blank_end[SKEW_LSB+:2]);
            hretrace <= skew_pick(retrace_raw, retrace_dly, horizontal_retrace_end[SKEW_LSB+:2]);
        end
    end

    assign vtotal_full = {vertical_overflow_bits[OVF_VT_BIT9], vertical_overflow_bits[OVF_VT_BIT8],
                          vertical_total};
    // lines run 0..total+1, so a frame is the programmed total plus two
    assign frame_end = ({1'b0, line_count} == ({1'b0, vtotal_full} + VTOTAL_EXTRA));

    // vertical line counter, one step per full line
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_count  <= 10'h000;
            frame_start <= 1'b0;
        end else begin
            frame_start <= 1'b0;
            if (char_tick && line_end) begin
                if (frame_end) begin
                    line_count  <= 10'h000;
                    frame_start <= 1'b1;
                end else begin
                    line_count  <= line_count + 10'h001;
                end
            end
        end
    end

    // row scan counter steps at retrace start, halved when doubling
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            row_scan  <= 5'h00;
            row_phase <= ROW_PHASE_STEP;
        end else if (char_tick && line_end && frame_end) begin
            // new frame restarts from the preset for smooth scrolling
            row_scan  <= preset_row_scan[4:0];
            row_phase <= ROW_PHASE_STEP;
        end else if (char_tick && retrace_start_hit && !retrace_raw) begin
            if (max_scan_line[MSL_DOUBLE_BIT] && row_phase == ROW_PHASE_HOLD) begin
                row_phase <= ROW_PHASE_STEP;
            end else begin
                row_phase <= max_scan_line[MSL_DOUBLE_BIT] ? ROW_PHASE_HOLD : ROW_PHASE_STEP;
                if (row_scan == max_scan_line[4:0]) begin
                    row_scan <= 5'h00;
                end else begin
                    row_scan <= row_scan + 5'h01;
                end
            end
        end
    end

    // cursor rows: start plus one through end, none if start beyond end
    assign cursor_first = {1'b0, cursor_start_row[4:0]} + 6'h01;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cursor_row <= 1'b0;
        end else begin
            cursor_row <= (cursor_start_row[4:0] <= cursor_end_row) &&
                          ({1'b0, row_scan} >= cursor_first) &&
                          (row_scan <= cursor_end_row);
        end
    end

    // extension bits handed to the vertical and panning logic elsewhere
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_pan            <= 2'b00;
            vblank_start_high   <= 10'h000;
            line_compare_high   <= 10'h000;
            vdisplay_end_high   <= 10'h000;
            vretrace_start_high <= 10'h000;
        end else begin
            byte_pan            <= preset_row_scan[SKEW_LSB+:2];
            vblank_start_high   <= {max_scan_line[MSL_VBS_BIT9], vertical_overflow_bits[OVF_VBS_BIT8],
                                    8'h00};
            line_compare_high   <= {max_scan_line[MSL_LC_BIT9], vertical_overflow_bits[OVF_LC_BIT8],
                                    8'h00};
            vdisplay_end_high   <= {vertical_overflow_bits[OVF_VDE_BIT9], vertical_overflow_bits[OVF_VDE_BIT8],
                                    8'h00};
            vretrace_start_high <= {vertical_overflow_bits[OVF_VRS_BIT9], vertical_overflow_bits[OVF_VRS_BIT8],
                                    8'h00};
        end
    end

endmodule

// >>> crt_raster_timing_regs_tb.sv
// testbench for the raster timing block
`timescale 1ns/100ps
module crt_raster_timing_regs_tb;
    import crt_timing_pkg::*;
    logic        sys_clk, resetn, char_tick = 1'b0, colour_select, write_protect, io_write, io_read, io_hit, h;
    logic        display_enable, hblank, hretrace, frame_start, cursor_row;
    logic [1:0]  byte_pan;
    logic [2:0]  prev_sig;
    logic [4:0]  cursor_end_row, row_scan, max_row;
    logic [7:0]  io_wdata, io_rdata, char_count, d;
    logic [9:0]  line_count, vblank_start_high, line_compare_high, vdisplay_end_high, vretrace_start_high;
    logic [15:0] io_addr, sync_count;
    int          err_total, cmp_count, ones, rise, r0, maxc;
    // 14-char lines, 4-line frames, 3-row characters
    logic [7:0]  vals [11] = '{8'h09, 8'h04, 8'h02, 8'h86, 8'h08, 8'h0B, 8'h02, 8'h00, 8'h61, 8'h02, 8'h05};
    wire logic [2:0] hsig = {hretrace, hblank, display_enable};
    crt_raster_timing_regs uut (.sys_clk, .resetn, .char_tick, .colour_select, .write_protect, .cursor_end_row,
        .io_addr, .io_write, .io_read, .io_wdata, .io_rdata, .io_hit, .display_enable, .hblank, .hretrace,
        .char_count, .line_count, .frame_start, .row_scan, .cursor_row, .byte_pan, .vblank_start_high,
        .line_compare_high, .vdisplay_end_high, .vretrace_start_high);
    crt_monitor_model monitor (.sys_clk, .hretrace, .frame_sync(frame_start), .sync_count);
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // tick every other cycle so idle cycles sit between characters
    always @(posedge sys_clk) begin
        char_tick <= ~char_tick;
        if (char_tick) prev_sig <= hsig;
    end
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one host cycle; read data and claim are taken one cycle after the strobe
    task automatic io(input logic [15:0] a, input logic [7:0] v, input logic wr);
        @(posedge sys_clk);
        io_addr  <= a;
        io_wdata <= v;
        io_write <= wr;
        io_read  <= ~wr;
        @(posedge sys_clk);
        io_write <= 1'b0;
        io_read  <= 1'b0;
        #1;
        d = io_rdata;
        h = io_hit;
    endtask
    task automatic wreg(input logic [7:0] i, input logic [7:0] v);
        io(COLOUR_INDEX_PORT, i, 1'b1);
        io(COLOUR_DATA_PORT, v, 1'b1);
    endtask
    task automatic rreg(input logic [7:0] i, input logic [7:0] e);
        io(COLOUR_INDEX_PORT, i, 1'b1);
        io(COLOUR_DATA_PORT, 8'h00, 1'b0);
        check("data", 10'(d), 10'(e));
        check("claim", 10'(h), 10'h001);
    endtask
    // skip one line for the skew pipeline to settle, then sample one full line per tick
    task automatic meas(input int sel);
        ones = 0;
        maxc = 0;
        repeat (14) @(posedge sys_clk iff char_tick);
        repeat (14) begin
            @(posedge sys_clk iff char_tick);
            ones += int'(hsig[sel]);
            if (hsig[sel] && !prev_sig[sel]) rise = int'(char_count);
            maxc = (int'(char_count) > maxc) ? int'(char_count) : maxc;
        end
    endtask
    // bounded wait for the frame pulse, noting the highest row scan on the way
    task automatic wait_frame();
        max_row = 5'h00;
        @(posedge sys_clk);
        for (int n = 0; n < 1000 && frame_start !== 1'b1; n++) begin
            @(posedge sys_clk);
            max_row = (row_scan > max_row) ? row_scan : max_row;
        end
        check("frame pulse", 10'(frame_start), 10'h001);
        if (frame_start !== 1'b1) complete_run();
    endtask
    // row scan steps and cursor-row characters over n ticks, once the cursor has settled
    task automatic rows(input int n);
        ones = 0;
        rise = 0;
        repeat (2) @(posedge sys_clk);
        repeat (n) begin
            max_row = row_scan;
            @(posedge sys_clk iff char_tick);
            ones += int'(row_scan != max_row);
            rise += int'(cursor_row);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        {resetn, colour_select, write_protect, io_write, io_read} = 5'h00;
        {cursor_end_row, io_addr, io_wdata} = 29'h00000000;
        err_total = 0;
        cmp_count = 0;
        repeat (6) @(posedge sys_clk);
        resetn        <= 1'b1;
        colour_select <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 11; i++) wreg(8'(i), vals[i]);
        for (int i = 0; i < 11; i++) rreg(8'(i), vals[i]);
        io(COLOUR_INDEX_PORT, 8'hE9, 1'b1);
        io(COLOUR_INDEX_PORT, 8'h00, 1'b0);
        check("index", 10'(d), 10'h029);
        io(COLOUR_DATA_PORT, 8'h00, 1'b0);
        check("decode", 10'(d), 10'h002);
        rreg(8'h0C, 8'h00);
        meas(0);
        check("line end", 10'(maxc), 10'h00D);
        check("display", 10'(ones), 10'h005);
        r0 = rise;
        wreg(8'h03, 8'hE6);
        meas(0);
        check("display skew", 10'((rise - r0 + 14) % 14), 10'h003);
        meas(1);
        check("blank", 10'(ones), 10'h004);
        meas(2);
        check("retrace", 10'(ones), 10'h003);
        r0 = rise;
        wreg(8'h05, 8'h6B);
        meas(2);
        check("retrace skew", 10'((rise - r0 + 14) % 14), 10'h003);
        wait_frame();
        check("preset row", 10'(row_scan), 10'h001);
        wait_frame();
        check("row max", 10'(max_row), 10'h002);
        check("syncs", 10'(sync_count), 10'h004);
        check("byte pan", 10'(byte_pan), 10'h003);
        write_protect <= 1'b1;
        wreg(8'h02, 8'h55);
        wreg(8'h07, 8'hFF);
        wreg(8'h09, 8'h62);
        rreg(8'h02, 8'h02);
        rreg(8'h07, 8'h10);
        check("compare high", line_compare_high, 10'h300);
        check("vblank high", vblank_start_high, 10'h200);
        @(posedge sys_clk);
        write_protect <= 1'b0;
        wreg(8'h07, 8'hE0);
        rreg(8'h07, 8'hE0);
        check("vde high", vdisplay_end_high, 10'h200);
        check("vrs high", vretrace_start_high, 10'h200);
        @(posedge sys_clk);
        cursor_end_row <= 5'h01;
        wreg(8'h0A, 8'h00);
        rows(42);
        check("row steps", 10'(ones), 10'h003);
        check("cursor rows", 10'(rise), 10'h00E);
        wreg(8'h09, 8'h82);
        rows(84);
        check("doubled steps", 10'(ones), 10'h003);
        check("doubled cursor", 10'(rise), 10'h01C);
        @(posedge sys_clk);
        colour_select <= 1'b0;
        io(MONO_DATA_PORT, 8'h00, 1'b0);
        check("mono claim", 10'(h), 10'h001);
        io(COLOUR_DATA_PORT, 8'h00, 1'b0);
        check("colour idle", 10'(h), 10'h000);
        complete_run();
    end
endmodule

// >>> crt_timing_pkg.sv
// constants and types shared by the raster timing block
package crt_timing_pkg;
    // i/o port addresses
    localparam logic [15:0] MONO_INDEX_PORT   = 16'h03B4;
    localparam logic [15:0] MONO_DATA_PORT    = 16'h03B5;
    localparam logic [15:0] COLOUR_INDEX_PORT = 16'h03D4;
    localparam logic [15:0] COLOUR_DATA_PORT  = 16'h03D5;
    // register indexes
    localparam logic [4:0] IDX_HORIZONTAL_TOTAL   = 5'h00;
    localparam logic [4:0] IDX_HORIZONTAL_DISPLAY = 5'h01;
    localparam logic [4:0] IDX_HBLANK_START       = 5'h02;
    localparam logic [4:0] IDX_HBLANK_END         = 5'h03;
    localparam logic [4:0] IDX_HRETRACE_START     = 5'h04;
    localparam logic [4:0] IDX_HRETRACE_END       = 5'h05;
    localparam logic [4:0] IDX_VERTICAL_TOTAL     = 5'h06;
    localparam logic [4:0] IDX_OVERFLOW           = 5'h07;
    localparam logic [4:0] IDX_PRESET_ROW_SCAN    = 5'h08;
    localparam logic [4:0] IDX_MAX_SCAN_LINE      = 5'h09;
    localparam logic [4:0] IDX_CURSOR_START       = 5'h0A;
    localparam logic [4:0] IDX_LAST_PROTECTED     = 5'h07;
    // field positions
    localparam int INDEX_TEST_BIT    = 5;
    localparam int SKEW_LSB          = 5;
    localparam int BLANK_END_BIT5    = 7;
    localparam int OVF_VT_BIT8       = 0;
    localparam int OVF_VDE_BIT8      = 1;
    localparam int OVF_VRS_BIT8      = 2;
    localparam int OVF_VBS_BIT8      = 3;
    localparam int OVF_LC_BIT8       = 4;
    localparam int OVF_VT_BIT9       = 5;
    localparam int OVF_VDE_BIT9      = 6;
    localparam int OVF_VRS_BIT9      = 7;
    localparam int MSL_VBS_BIT9      = 5;
    localparam int MSL_LC_BIT9       = 6;
    localparam int MSL_DOUBLE_BIT    = 7;
    // reset values and offsets
    localparam logic [7:0] REG_RESET_VALUE  = 8'h00;
    localparam logic [8:0] HTOTAL_EXTRA     = 9'h004;
    localparam logic [10:0] VTOTAL_EXTRA    = 11'h001; // frame is vertical total plus two lines
    localparam logic [5:0] INDEX_WRITE_MASK = 6'h3F;
    // line-doubling phase of the row scan clock
    typedef enum logic {ROW_PHASE_STEP, ROW_PHASE_HOLD} row_phase_type;
endpackage
